// File: design/motion_profile_parameter_bank.sv
module motion_profile_parameter_bank (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         reset_n_i,
	// parameter access from fieldbus
	input  wire motion_param_pkg::param_req_t param_req_i,
	output      motion_param_pkg::param_rsp_t param_rsp_o,
	// drive state
	input  wire logic                         power_stage_on_i,
	input  wire logic                         mode_finished_i,
	input  wire logic                         motion_start_i,
	input  wire logic                         power_on_event_i,
	// velocity ceilings
	input  wire logic [15:0]                  velocity_ceiling_i,
	input  wire logic [15:0]                  speed_ceiling_i,
	// position bounds from scaling and limits
	input  wire logic signed [31:0]           pos_min_i,
	input  wire logic signed [31:0]           pos_max_i,
	// transmit process data from motion logic
	input  wire logic [31:0]                  tx_word_a_i,
	input  wire logic [31:0]                  tx_word_b_i,
	// active settings to profile generator
	output      logic                         dir_ccw_o,
	output      logic [31:0]                  scale_num_o,
	output      logic [31:0]                  scale_den_o,
	output      logic [31:0]                  accel_o,
	output      logic [31:0]                  decel_o,
	output      logic [7:0]                   jerk_ms_o,
	output      logic                         rel_ref_actual_o,
	output      logic [31:0]                  pp_target_vel_o,
	output      logic signed [31:0]           pp_target_pos_o,
	output      logic signed [31:0]           pv_target_o,
	// receive process data to function blocks
	output      logic [31:0]                  rx_word_a_o,
	output      logic [31:0]                  rx_word_b_o
);
	import motion_param_pkg::*;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// unsigned inclusive range check
	function automatic logic in_range(input logic [31:0] v, lo, hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	// smaller of two ceilings
	function automatic logic [15:0] min16(input logic [15:0] a, b);
		min16 = (a < b) ? a : b;
	endfunction
	// ----------------------------------------------------------------
	// stored parameters
	// ----------------------------------------------------------------
	logic [31:0]        den_reg;      // written denominator
	logic [31:0]        num_reg;      // written numerator
	logic [31:0]        accel_reg;    // written acceleration
	logic [31:0]        decel_reg;    // written deceleration
	logic               dir_reg;      // written direction
	logic [7:0]         jerk_reg;     // written jerk code
	logic [31:0]        rx_a_reg;     // receive word a
	logic [31:0]        rx_b_reg;     // receive word b
	logic [31:0]        tx_a_reg;     // sampled transmit word a
	logic [31:0]        tx_b_reg;     // sampled transmit word b
	logic signed [31:0] pv_reg;       // written velocity target
	logic signed [31:0] pos_reg;      // written target position
	logic [31:0]        pp_vel_reg;   // written position velocity
	logic               rel_reg;      // written option, 1 = actual
	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	wire        wr = param_req_i.valid & param_req_i.write;
	wire [15:0] a  = param_req_i.addr;
	wire [31:0] d  = param_req_i.wdata;
	// per-register write qualifiers, including range and state
	wire ok_den = in_range(d, SCALE_MIN, SCALE_MAX) & ~power_stage_on_i;
	wire ok_num = in_range(d, SCALE_MIN, SCALE_MAX);
	wire ok_acc = in_range(d, ACCEL_MIN, RAMP_MAX);
	wire ok_dec = in_range(d, DECEL_MIN, RAMP_MAX);
	wire ok_dir = (d <= DIR_MAX) & ~power_stage_on_i;
	// jerk: zero or a single bit up to 128, and mode idle
	wire jerk_code = (d <= JERK_MAX) & ((d & (d - 32'h1)) == RST_ZERO);
	wire ok_jerk = jerk_code & mode_finished_i;
	wire ok_pvel = (d >= PP_VEL_MIN);
	wire ok_pos  = ($signed(d) >= pos_min_i) & ($signed(d) <= pos_max_i);
	wire ok_shp  = (d == SHAPE_LINEAR);
	wire ok_rel  = (d == REL_PREV_TARGET) | (d == REL_ACTUAL_POS);
	// address hit and acceptance
	logic        hit;      // address is mapped
	logic        ok;       // write acceptable
	logic [31:0] rd;       // read value
	// ----------------------------------------------------------------
	// address mux for reads and write checks
	// ----------------------------------------------------------------
	always_comb begin
		hit = 1'b1;
		ok  = 1'b0;
		rd  = RST_ZERO;
		unique case (a)
			ADDR_SCALE_DEN: begin
				ok = ok_den;
				rd = den_reg;
			end
			ADDR_SCALE_NUM: begin
				ok = ok_num;
				rd = num_reg;
			end
			ADDR_ACCEL: begin
				ok = ok_acc;
				rd = accel_reg;
			end
			ADDR_DECEL: begin
				ok = ok_dec;
				rd = decel_reg;
			end
			ADDR_ROT_DIR: begin
				ok = ok_dir;
				rd = {31'h0, dir_reg};
			end
			ADDR_JERK: begin
				ok = ok_jerk;
				rd = {24'h0, jerk_reg};
			end
			ADDR_RX_A: begin
				ok = 1'b1;
				rd = rx_a_reg;
			end
			ADDR_RX_B: begin
				ok = 1'b1;
				rd = rx_b_reg;
			end
			// transmit words are read-only: ok keeps its default of 0
			ADDR_TX_A: rd = tx_a_reg;
			ADDR_TX_B: rd = tx_b_reg;
			ADDR_PV_TARGET: begin
				ok = 1'b1;
				rd = pv_reg;
			end
			ADDR_PP_POS: begin
				ok = ok_pos;
				rd = pos_reg;
			end
			ADDR_PP_VEL: begin
				ok = ok_pvel;
				rd = pp_vel_reg;
			end
			ADDR_SHAPE: begin
				ok = ok_shp;
				rd = SHAPE_LINEAR;
			end
			ADDR_REL_OPT: begin
				ok = ok_rel;
				rd = rel_reg ? REL_ACTUAL_POS : REL_PREV_TARGET;
			end
			// unmapped address
			default: hit = 1'b0;
		endcase
	end

	// accepted write strobe
	wire wr_ok = wr & hit & ok;
	// ----------------------------------------------------------------
	// answer: one cycle after the request
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			param_rsp_o <= '0;
		end else begin
			param_rsp_o.ack   <= param_req_i.valid;
			// rejection leaves stored value untouched
			param_rsp_o.err   <= param_req_i.valid
				& (~hit | (param_req_i.write & ~ok));
			param_rsp_o.rdata <= (param_req_i.valid & ~param_req_i.write & hit)
				? rd : RST_ZERO;
		end
	end
	// ----------------------------------------------------------------
	// scaling: numerator write activates the pair
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			den_reg     <= RST_SCALE_DEN;
			num_reg     <= RST_SCALE_NUM;
			scale_num_o <= RST_SCALE_NUM;
			scale_den_o <= RST_SCALE_DEN;
		end else begin
			// denominator alone stays pending
			if (wr_ok && a == ADDR_SCALE_DEN) begin
				den_reg <= d;
			end
			// revolutions over user units take effect now
			if (wr_ok && a == ADDR_SCALE_NUM) begin
				num_reg     <= d;
				scale_num_o <= d;
				scale_den_o <= den_reg;
			end
		end
	end
	// ----------------------------------------------------------------
	// direction: stored now, applied at next power-on
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dir_reg   <= 1'b0;
			dir_ccw_o <= 1'b0;
		end else begin
			if (wr_ok && a == ADDR_ROT_DIR) begin
				dir_reg <= d[0];
			end
			// 0 clockwise, 1 counter-clockwise
			if (power_on_event_i) begin
				dir_ccw_o <= dir_reg;
			end
		end
	end
	// ----------------------------------------------------------------
	// ramp, jerk, option and velocity: stored copies
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			accel_reg  <= RST_ACCEL;
			decel_reg  <= RST_DECEL;
			jerk_reg   <= 8'h00;
			rel_reg    <= 1'b0;
			pp_vel_reg <= RST_PP_VEL;
		end else if (wr_ok) begin
			if (a == ADDR_ACCEL) begin
				accel_reg <= d;
			end
			if (a == ADDR_DECEL) begin
				decel_reg <= d;
			end
			if (a == ADDR_JERK) begin
				jerk_reg <= d[7:0];
			end
			if (a == ADDR_REL_OPT) begin
				rel_reg <= d[1];
			end
			if (a == ADDR_PP_VEL) begin
				pp_vel_reg <= d;
			end
		end
	end

	// effective ceiling is the lower of both maxima
	wire [15:0] ceil16 = min16(velocity_ceiling_i, speed_ceiling_i);
	wire [31:0] ceil   = {16'h0, ceil16};
	// ----------------------------------------------------------------
	// active set taken at the start of each motion
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			accel_o          <= RST_ACCEL;
			decel_o          <= RST_DECEL;
			jerk_ms_o        <= 8'h00;
			rel_ref_actual_o <= 1'b0;
			pp_target_vel_o  <= RST_PP_VEL;
		end else if (motion_start_i) begin
			accel_o          <= accel_reg;
			decel_o          <= decel_reg;
			jerk_ms_o        <= jerk_reg;
			rel_ref_actual_o <= rel_reg;
			pp_target_vel_o  <= (pp_vel_reg > ceil)
				? ceil : pp_vel_reg;
		end
	end

	// ----------------------------------------------------------------
	// immediate parameters and process data
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pv_reg   <= RST_ZERO;
			pos_reg  <= RST_ZERO;
			rx_a_reg <= RST_ZERO;
			rx_b_reg <= RST_ZERO;
		end else if (wr_ok) begin
			if (a == ADDR_PV_TARGET) begin
				pv_reg <= d;
			end
			if (a == ADDR_PP_POS) begin
				pos_reg <= d;
			end
			if (a == ADDR_RX_A) begin
				rx_a_reg <= d;
			end
			if (a == ADDR_RX_B) begin
				rx_b_reg <= d;
			end
		end
	end

	// signed clamp of the velocity target to +/- ceiling
	wire signed [31:0] pos_ceil = $signed(ceil);
	wire signed [31:0] neg_ceil = -$signed(ceil);
	wire signed [31:0] pv_lim   = (pv_reg > pos_ceil) ? pos_ceil
		: ((pv_reg < neg_ceil) ? neg_ceil : pv_reg);

	// ----------------------------------------------------------------
	// output copies one cycle behind the stored value (velocity target clamped), and transmit words sampled from the inputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pv_target_o     <= RST_ZERO;
			pp_target_pos_o <= RST_ZERO;
			rx_word_a_o     <= RST_ZERO;
			rx_word_b_o     <= RST_ZERO;
			tx_a_reg        <= RST_ZERO;
			tx_b_reg        <= RST_ZERO;
		end else begin
			pv_target_o     <= pv_lim;
			pp_target_pos_o <= pos_reg;
			rx_word_a_o     <= rx_a_reg;
			rx_word_b_o     <= rx_b_reg;
			tx_a_reg        <= tx_word_a_i;
			tx_b_reg        <= tx_word_b_i;
		end
	end

endmodule

// File: pkg/motion_param_pkg.sv
package motion_param_pkg;

	// ----------------------------------------------------------------
	// fieldbus parameter addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_SCALE_DEN  = 16'h060E;
	localparam logic [15:0] ADDR_SCALE_NUM  = 16'h0610;
	localparam logic [15:0] ADDR_ACCEL      = 16'h0614;
	localparam logic [15:0] ADDR_DECEL      = 16'h0616;
	localparam logic [15:0] ADDR_ROT_DIR    = 16'h0618;
	localparam logic [15:0] ADDR_JERK       = 16'h061A;
	localparam logic [15:0] ADDR_RX_A       = 16'h1B0A;
	localparam logic [15:0] ADDR_RX_B       = 16'h1B0C;
	localparam logic [15:0] ADDR_TX_A       = 16'h1B0E;
	localparam logic [15:0] ADDR_TX_B       = 16'h1B10;
	localparam logic [15:0] ADDR_PV_TARGET  = 16'h1B1A;
	localparam logic [15:0] ADDR_PP_POS     = 16'h1B1C;
	localparam logic [15:0] ADDR_PP_VEL     = 16'h1B1E;
	localparam logic [15:0] ADDR_SHAPE      = 16'h1B2A;
	localparam logic [15:0] ADDR_REL_OPT    = 16'h1B30;

	// ----------------------------------------------------------------
	// reset (factory) values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_SCALE_DEN   = 32'h0000_4000;
	localparam logic [31:0] RST_SCALE_NUM   = 32'h0000_0001;
	localparam logic [31:0] RST_ACCEL       = 32'h0000_0258;
	localparam logic [31:0] RST_DECEL       = 32'h0000_02EE;
	localparam logic [31:0] RST_PP_VEL      = 32'h0000_003C;
	localparam logic [31:0] RST_ZERO        = 32'h0000_0000;

	// ----------------------------------------------------------------
	// value ranges
	// ----------------------------------------------------------------
	localparam logic [31:0] SCALE_MIN       = 32'h0000_0001;
	localparam logic [31:0] SCALE_MAX       = 32'h7FFF_FFFF;
	localparam logic [31:0] ACCEL_MIN       = 32'h0000_0001;
	localparam logic [31:0] DECEL_MIN       = 32'h0000_02EE;
	localparam logic [31:0] RAMP_MAX        = 32'h002D_C6C0;
	localparam logic [31:0] PP_VEL_MIN      = 32'h0000_0001;
	localparam logic [31:0] DIR_MAX         = 32'h0000_0001;
	localparam logic [31:0] SHAPE_LINEAR    = 32'h0000_0000;
	localparam logic [31:0] REL_PREV_TARGET = 32'h0000_0000;
	localparam logic [31:0] REL_ACTUAL_POS  = 32'h0000_0002;
	localparam logic [31:0] JERK_MAX        = 32'h0000_0080;

	// ----------------------------------------------------------------
	// request and answer carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;  // one-cycle request strobe
		logic        write;  // 1 write, 0 read
		logic [15:0] addr;   // fieldbus parameter address
		logic [31:0] wdata;  // write value
	} param_req_t;

	typedef struct packed {
		logic        ack;    // one-cycle answer strobe
		logic        err;    // request rejected
		logic [31:0] rdata;  // read value, zero on error
	} param_rsp_t;

endpackage

// File: sim/fieldbus_master_model.sv
// ----------------------------------------------------------------
// fieldbus master: one-cycle request pulse, answer one cycle later
// ----------------------------------------------------------------
module fieldbus_master_model
	import motion_param_pkg::*;
(
	// clock
	input  wire logic       clk_i,
	// parameter port
	output      param_req_t req_o,
	input  wire param_rsp_t rsp_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle request at time zero
	initial req_o = '0;

	// one transfer; released lines show the inverse of the last value
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic k, output logic e, output logic [31:0] q);
		@(posedge clk_i);
		req_o <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(posedge clk_i);
		req_o <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
		#1;
		k = rsp_i.ack;
		e = rsp_i.err;
		q = rsp_i.rdata;
	endtask
endmodule

// File: sim/motion_profile_parameter_bank_checker.sv
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module motion_profile_parameter_bank_checker
	import motion_param_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire param_req_t param_req_i,
	input wire param_rsp_t param_rsp_o,
	input wire logic       power_stage_on_i,
	input wire logic       mode_finished_i,
	input wire logic       motion_start_i,
	input wire logic       power_on_event_i,
	input wire logic       dir_ccw_o,
	input wire logic [31:0] scale_den_o,
	input wire logic [31:0] accel_o,
	input wire logic [7:0] jerk_ms_o
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// write request decode
	wire       wr_go = param_req_i.valid && param_req_i.write;
	wire [15:0] wa   = param_req_i.addr;

	property p_ack; param_req_i.valid |=> param_rsp_o.ack; endproperty
	a_ack: assert property (p_ack) else $error("no answer");
	property p_quiet; !param_req_i.valid |=> !param_rsp_o.ack; endproperty
	a_quiet: assert property (p_quiet) else $error("stray answer");
	property p_tx_ro; wr_go && (wa == ADDR_TX_A || wa == ADDR_TX_B) |=> param_rsp_o.err;
	endproperty
	a_tx_ro: assert property (p_tx_ro) else $error("tx write taken");
	property p_dir_gate; wr_go && wa == ADDR_ROT_DIR && power_stage_on_i |=> param_rsp_o.err;
	endproperty
	a_dir_gate: assert property (p_dir_gate) else $error("dir write taken");
	property p_den_gate; wr_go && wa == ADDR_SCALE_DEN && power_stage_on_i |=> param_rsp_o.err;
	endproperty
	a_den_gate: assert property (p_den_gate) else $error("den write taken");
	property p_jerk_gate; wr_go && wa == ADDR_JERK && !mode_finished_i |=> param_rsp_o.err;
	endproperty
	a_jerk_gate: assert property (p_jerk_gate) else $error("jerk write taken");
	property p_shape; wr_go && wa == ADDR_SHAPE && param_req_i.wdata != 32'h0 |=> param_rsp_o.err;
	endproperty
	a_shape: assert property (p_shape) else $error("shape taken");
	property p_dir_hold; !power_on_event_i |=> $stable(dir_ccw_o); endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("dir moved");
	property p_den_hold; !(wr_go && wa == ADDR_SCALE_NUM) |=> $stable(scale_den_o); endproperty
	a_den_hold: assert property (p_den_hold) else $error("den moved");
	property p_acc_hold; !motion_start_i |=> $stable(accel_o); endproperty
	a_acc_hold: assert property (p_acc_hold) else $error("accel moved");
	property p_jerk_hold; !motion_start_i |=> $stable(jerk_ms_o); endproperty
	a_jerk_hold: assert property (p_jerk_hold) else $error("jerk moved");
endmodule

bind motion_profile_parameter_bank motion_profile_parameter_bank_checker i_checker (
	.clk_i, .reset_n_i, .param_req_i, .param_rsp_o, .power_stage_on_i, .mode_finished_i,
	.motion_start_i, .power_on_event_i, .dir_ccw_o, .scale_den_o, .accel_o, .jerk_ms_o);

// File: sim/motion_profile_parameter_bank_test.sv
module motion_profile_parameter_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	import motion_param_pkg::*;
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH %0t %s", $time, m); end end

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic clk_i = 1'b0, reset_n_i = 1'b0;
	param_req_t req;
	param_rsp_t rsp;
	logic pwr = 1'b0, fin = 1'b1, mstart = 1'b0, pon = 1'b0;
	logic [15:0] vceil = 16'h0064, sceil = 16'h00C8;
	logic signed [31:0] pmin = 32'hFFFF_FC18, pmax = 32'h0000_03E8, ppp, pv;
	logic [31:0] txa = 32'h0, txb = 32'h0, snum, sden, acc, dec, ppv, rxa, rxb;
	logic [7:0] jerk;
	logic dir, rel;
	int n_errors = 0, n_checks = 0;
	logic [31:0] shadow [logic [15:0]]; // expected stored values

	always #12.5 clk_i = ~clk_i;

	motion_profile_parameter_bank i_motion_profile_parameter_bank (
		.clk_i, .reset_n_i, .param_req_i(req), .param_rsp_o(rsp), .power_stage_on_i(pwr),
		.mode_finished_i(fin), .motion_start_i(mstart), .power_on_event_i(pon),
		.velocity_ceiling_i(vceil), .speed_ceiling_i(sceil), .pos_min_i(pmin), .pos_max_i(pmax),
		.tx_word_a_i(txa), .tx_word_b_i(txb), .dir_ccw_o(dir), .scale_num_o(snum),
		.scale_den_o(sden), .accel_o(acc), .decel_o(dec), .jerk_ms_o(jerk),
		.rel_ref_actual_o(rel), .pp_target_vel_o(ppv), .pp_target_pos_o(ppp),
		.pv_target_o(pv), .rx_word_a_o(rxa), .rx_word_b_o(rxb));
	fieldbus_master_model i_fieldbus_master_model (.clk_i, .req_o(req), .rsp_i(rsp));

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ee);
		logic k, e;
		logic [31:0] q;
		i_fieldbus_master_model.xfer(1'b1, a, d, k, e, q);
		`CHK(k, 1'b1, "no ack")
		`CHK(e, ee, "write err flag")
		if (!ee && shadow.exists(a)) shadow[a] = d;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic ee);
		logic k, e;
		logic [31:0] q;
		i_fieldbus_master_model.xfer(1'b0, a, 32'h0, k, e, q);
		`CHK(k, 1'b1, "no ack")
		`CHK(e, ee, "read err flag")
		`CHK(q, x, "read data")
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// one-cycle pulse of motion start (0) or power-on (1)
	task automatic pulse(input bit p);
		@(posedge clk_i);
		if (p) pon <= 1'b1;
		else mstart <= 1'b1;
		@(posedge clk_i);
		pon <= 1'b0;
		mstart <= 1'b0;
		#1;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// watchdog at 5000 cycles, well beyond the roughly 150 cycles the tests need
	initial begin
		#(25 * 5000);
		n_errors++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		shadow[ADDR_SCALE_DEN] = RST_SCALE_DEN;
		shadow[ADDR_SCALE_NUM] = RST_SCALE_NUM;
		shadow[ADDR_ACCEL] = RST_ACCEL;
		shadow[ADDR_DECEL] = RST_DECEL;
		shadow[ADDR_PP_VEL] = RST_PP_VEL;
		shadow[ADDR_ROT_DIR] = 32'h0;
		shadow[ADDR_JERK] = 32'h0;
		shadow[ADDR_SHAPE] = 32'h0;
		shadow[ADDR_REL_OPT] = 32'h0;
		shadow[ADDR_PV_TARGET] = 32'h0;
		shadow[ADDR_RX_A] = 32'h0;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		foreach (shadow[a]) rd(a, shadow[a], 1'b0);
		`CHK(sden, 32'h0000_4000, "den out")
		$display("test reset values done");
		wr(ADDR_SCALE_DEN, 32'h0, 1'b1);
		wr(ADDR_SCALE_DEN, 32'h8000_0000, 1'b1);
		wr(ADDR_SCALE_NUM, 32'h0, 1'b1);
		wr(ADDR_ACCEL, 32'h0, 1'b1);
		wr(ADDR_ACCEL, 32'h002D_C6C1, 1'b1);
		wr(ADDR_ACCEL, 32'h002D_C6C0, 1'b0);
		wr(ADDR_DECEL, 32'h0000_02ED, 1'b1);
		wr(ADDR_DECEL, 32'h002D_C6C0, 1'b0);
		wr(ADDR_ROT_DIR, 32'h2, 1'b1);
		wr(ADDR_SHAPE, 32'h1, 1'b1);
		wr(ADDR_SHAPE, 32'h0, 1'b0);
		wr(ADDR_REL_OPT, 32'h1, 1'b1);
		wr(ADDR_REL_OPT, 32'h2, 1'b0);
		wr(ADDR_PP_VEL, 32'h0, 1'b1);
		wr(ADDR_TX_A, 32'h5, 1'b1);
		wr(16'h0600, 32'h5, 1'b1);
		rd(16'h0600, 32'h0, 1'b1);
		wr(ADDR_JERK, 32'h3, 1'b1);
		wr(ADDR_JERK, 32'h100, 1'b1);
		for (int i = 0; i < 8; i++) wr(ADDR_JERK, 32'h1 << i, 1'b0);
		foreach (shadow[a]) rd(a, shadow[a], 1'b0);
		$display("test ranges done");
		@(posedge clk_i);
		pwr <= 1'b1;
		fin <= 1'b0;
		wr(ADDR_ROT_DIR, 32'h1, 1'b1);
		wr(ADDR_SCALE_DEN, 32'h100, 1'b1);
		wr(ADDR_JERK, 32'h0, 1'b1);
		@(posedge clk_i);
		pwr <= 1'b0;
		fin <= 1'b1; // jerk writes are accepted only once the mode is finished
		wr(ADDR_SCALE_DEN, 32'h100, 1'b0);
		tick(2);
		`CHK(sden, 32'h0000_4000, "den early")
		wr(ADDR_SCALE_NUM, 32'h3, 1'b0);
		`CHK(snum, 32'h3, "num active")
		`CHK(sden, 32'h100, "den active")
		$display("test gates and scaling done");
		wr(ADDR_PP_VEL, 32'h1F4, 1'b0);
		`CHK(acc, 32'h0000_0258, "accel early")
		pulse(1'b0);
		`CHK(acc, 32'h002D_C6C0, "accel")
		`CHK(dec, 32'h002D_C6C0, "decel")
		`CHK(jerk, 8'h80, "jerk")
		`CHK(rel, 1'b1, "rel ref")
		`CHK(ppv, 32'h64, "pp vel clamp")
		wr(ADDR_ROT_DIR, 32'h1, 1'b0);
		`CHK(dir, 1'b0, "dir early")
		pulse(1'b1);
		`CHK(dir, 1'b1, "dir ccw")
		$display("test next motion done");
		wr(ADDR_PV_TARGET, 32'hFFFF_FC18, 1'b0);
		wr(ADDR_PP_POS, 32'h0000_07D0, 1'b1);
		wr(ADDR_PP_POS, 32'hFFFF_FE0C, 1'b0);
		wr(ADDR_RX_A, 32'h0000_5A5A, 1'b0);
		wr(ADDR_RX_B, 32'hA5A5_0001, 1'b0);
		tick(1);
		`CHK(pv, 32'hFFFF_FF9C, "pv clamp")
		`CHK(ppp, 32'hFFFF_FE0C, "target pos")
		`CHK(rxa, 32'h0000_5A5A, "rx a")
		`CHK(rxb, 32'hA5A5_0001, "rx b")
		@(posedge clk_i);
		txa <= 32'h1234_5678;
		txb <= 32'h8765_4321;
		tick(2);
		rd(ADDR_TX_A, 32'h1234_5678, 1'b0);
		rd(ADDR_TX_B, 32'h8765_4321, 1'b0);
		$display("test immediate words done");
		wrap_up();
	end
endmodule
